//--- alpm_ctrl.sv
// Low-power mode controller: normal, light-sleep and deep-sleep sequencing
//
// Behaviour
// - Power-control writes accepted only after unlock key
// - Light-sleep entered at conversion end, pin high
// - Falling pin edge leaves light-sleep
// - Deep-sleep entered on next rising pin edge seen in ST_ACQ
// - Deep-sleep powers analog down, keeps registers
// - Ready indicator high during deep-sleep
// - Clearing deep-sleep bit starts wake, ready high
// - Normal mode keeps analog powered between conversions
`timescale 1ns/1ns
module alpm_ctrl (
  input  wire logic       CLOCK_I,       // 10 MHz clock
  input  wire logic       SYS_RST_I,     // Synchronous reset, high
  input  wire logic       CONV_START_SELECT_I, // Conversion start/select pin
  input  wire logic       REG_WR_I,      // Register write strobe from serial interface
  input  wire logic [7:0] REG_ADDR_I,    // Register write address
  input  wire logic [7:0] REG_DATA_I,    // Register write data
  output logic      [7:0] PWRCTL_O,      // Power control register contents
  output logic            UNLOCKED_O,    // Power control register unlocked
  output logic            ANALOG_PWR_O,  // Analog circuitry powered
  output logic            LIGHT_SLEEP_O, // In light-sleep mode
  output logic            DEEP_SLEEP_O,  // In deep-sleep mode
  output logic            CONV_BUSY_O,   // Conversion in progress
  output logic            HOST_READY_O   // Ready indicator pin
);

  // ****************************************************************
  // Pin synchroniser and edge detection
  // ****************************************************************
  logic cs_meta_ff;
  logic cs_sync_ff;
  logic cs_prev_ff;
  logic cs_rise;
  logic cs_fall;

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      cs_meta_ff <= 1'b0;
      cs_sync_ff <= 1'b0;
      cs_prev_ff <= 1'b0;
    end else begin
      cs_meta_ff <= CONV_START_SELECT_I;
      cs_sync_ff <= cs_meta_ff;
      cs_prev_ff <= cs_sync_ff;
    end
  end

  assign cs_rise = cs_sync_ff & ~cs_prev_ff;
  assign cs_fall = ~cs_sync_ff & cs_prev_ff;

  // ****************************************************************
  // Unlock key and power control register
  // ****************************************************************
  logic       unlocked_ff;
  logic [7:0] pwrctl_ff;

  // Unlock stays in force until reset or another write to the unlock address, so the host may later clear deep-sleep
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      unlocked_ff <= 1'b0;
    end else if (REG_WR_I && REG_ADDR_I == alpm_pkg::UNLOCK_ADDR) begin
      unlocked_ff <= (REG_DATA_I == alpm_pkg::UNLOCK_KEY);
    end
  end

  // Register contents are kept in every mode, deep-sleep included
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      pwrctl_ff <= alpm_pkg::PWRCTL_RESET;
    end else if (REG_WR_I && REG_ADDR_I == alpm_pkg::PWRCTL_ADDR && unlocked_ff) begin
      pwrctl_ff <= REG_DATA_I;
    end
  end

  logic light_en;
  logic deep_req;
  assign light_en = pwrctl_ff[alpm_pkg::LIGHT_EN_BIT];
  assign deep_req = pwrctl_ff[alpm_pkg::DEEP_REQ_BIT];

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  typedef logic [alpm_pkg::CNT_W-1:0] alpm_cnt_t;

  alpm_pkg::alpm_state_t state_ff;
  alpm_pkg::alpm_state_t nxt_state;
  alpm_cnt_t             cnt_ff;
  alpm_cnt_t             nxt_cnt;
  logic                  cnt_done;
  logic                  conv_end;
  logic                  light_entry;
  logic                  deep_entry;
  logic                  deep_exit;

  assign cnt_done    = (cnt_ff == '0);
  assign conv_end    = (state_ff == alpm_pkg::ST_CONV) && cnt_done;
  // Pin level is taken after the synchroniser, so a glitch caught on a clock edge
  // near the end of conversion still reaches the light-sleep decision
  assign light_entry = conv_end && light_en && cs_sync_ff;
  assign deep_entry  = cs_rise && deep_req;
  assign deep_exit   = ~deep_req;

  // Deep-sleep wins over a new conversion on the same rising edge, so an
  // armed converter never starts a conversion it was told to skip
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      alpm_pkg::ST_ACQ: begin
        if (deep_entry) begin
          nxt_state = alpm_pkg::ST_DEEP_SLEEP;
          nxt_cnt   = '0;
        end else if (cs_rise) begin
          nxt_state = alpm_pkg::ST_CONV;
          nxt_cnt   = alpm_cnt_t'(alpm_pkg::CONV_CYCLES - 1);
        end
      end
      alpm_pkg::ST_CONV: begin
        if (!cnt_done) begin
          nxt_cnt = cnt_ff - alpm_cnt_t'(1);
        end else if (light_entry) begin
          nxt_state = alpm_pkg::ST_LIGHT_SLEEP;
        end else begin
          nxt_state = alpm_pkg::ST_ACQ;
        end
      end
      alpm_pkg::ST_LIGHT_SLEEP: begin
        if (cs_fall) begin
          nxt_state = alpm_pkg::ST_LIGHT_WAKE;
          nxt_cnt   = alpm_cnt_t'(alpm_pkg::LIGHT_WAKE_CYCLES - 1);
        end
      end
      // A rising edge here breaks the host's wake wait and is ignored
      alpm_pkg::ST_LIGHT_WAKE: begin
        if (!cnt_done) begin
          nxt_cnt = cnt_ff - alpm_cnt_t'(1);
        end else begin
          nxt_state = alpm_pkg::ST_ACQ;
        end
      end
      alpm_pkg::ST_DEEP_SLEEP: begin
        if (deep_exit) begin
          nxt_state = alpm_pkg::ST_DEEP_WAKE;
          nxt_cnt   = alpm_cnt_t'(alpm_pkg::DEEP_WAKE_CYCLES - 1);
        end
      end
      alpm_pkg::ST_DEEP_WAKE: begin
        if (!cnt_done) begin
          nxt_cnt = cnt_ff - alpm_cnt_t'(1);
        end else begin
          nxt_state = alpm_pkg::ST_ACQ;
        end
      end
      default: begin
        nxt_state = alpm_pkg::ST_ACQ;
        nxt_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_ff <= alpm_pkg::ST_ACQ;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ****************************************************************
  // Mode flags and pins
  // ****************************************************************
  logic analog_pwr_ff;
  logic light_sleep_ff;
  logic deep_sleep_ff;
  logic conv_busy_ff;
  logic host_ready_ff;

  // Flags are registered from the next state so they change on the same
  // edge as the mode itself and never glitch at the pins.
  // Light-sleep only trims internal bias, so the supply stays on and
  // its wake is short; only deep-sleep cuts analog power.
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      analog_pwr_ff  <= alpm_pkg::ANALOG_PWR_RESET;
      light_sleep_ff <= alpm_pkg::MODE_FLAG_RESET;
      deep_sleep_ff  <= alpm_pkg::MODE_FLAG_RESET;
      conv_busy_ff   <= alpm_pkg::MODE_FLAG_RESET;
      host_ready_ff  <= alpm_pkg::HOST_READY_RESET;
    end else begin
      analog_pwr_ff  <= (nxt_state != alpm_pkg::ST_DEEP_SLEEP);
      light_sleep_ff <= (nxt_state == alpm_pkg::ST_LIGHT_SLEEP);
      deep_sleep_ff  <= (nxt_state == alpm_pkg::ST_DEEP_SLEEP);
      conv_busy_ff   <= (nxt_state == alpm_pkg::ST_CONV);
      host_ready_ff  <= (nxt_state != alpm_pkg::ST_CONV);
    end
  end

  assign PWRCTL_O      = pwrctl_ff;
  assign UNLOCKED_O    = unlocked_ff;
  assign ANALOG_PWR_O  = analog_pwr_ff;
  assign LIGHT_SLEEP_O = light_sleep_ff;
  assign DEEP_SLEEP_O  = deep_sleep_ff;
  assign CONV_BUSY_O   = conv_busy_ff;
  assign HOST_READY_O  = host_ready_ff;

endmodule

//--- alpm_host.sv
// Host controller model: pin and register writes
`timescale 1ns/1ns
module alpm_host(input wire logic CLOCK_I, output logic CONV_START_SELECT_I, REG_WR_I,
  output logic [7:0] REG_ADDR_I, REG_DATA_I);
  initial {CONV_START_SELECT_I, REG_WR_I, REG_ADDR_I, REG_DATA_I} = 0;
  // Released address and data show the inverse, not a stale copy
  task w(input logic [7:0] x, y);
    @(posedge CLOCK_I) {REG_WR_I, REG_ADDR_I, REG_DATA_I} <= {1'b1, x, y};
    @(posedge CLOCK_I) {REG_WR_I, REG_ADDR_I, REG_DATA_I} <= {1'b0, ~x, ~y};
  endtask
  task p(input logic v, int n);
    @(posedge CLOCK_I) CONV_START_SELECT_I <= v;
    repeat (n) @(posedge CLOCK_I);
    #1;
  endtask
endmodule

//--- alpm_pkg.sv
// Package with constants and types for the converter low-power mode control
package alpm_pkg;

  // ****************************************************************
  // Register access
  // ****************************************************************
  localparam logic [7:0] UNLOCK_ADDR       = 8'h05;
  localparam logic [7:0] UNLOCK_KEY        = 8'h69;
  localparam logic [7:0] PWRCTL_ADDR       = 8'h04;
  localparam int         LIGHT_EN_BIT      = 0;
  localparam int         DEEP_REQ_BIT      = 1;
  localparam logic [7:0] PWRCTL_RESET      = 8'h00;
  localparam logic       ANALOG_PWR_RESET  = 1'b1;
  localparam logic       HOST_READY_RESET  = 1'b1;
  localparam logic       MODE_FLAG_RESET   = 1'b0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ                    = 10000000;
  localparam int CONV_TIME_NS              = 1000;
  localparam int LIGHT_WAKE_TIME_NS        = 1000;
  localparam int DEEP_WAKE_TIME_NS         = 10000;
  localparam int NS_PER_CYCLE              = 1000000000 / CLK_HZ;
  localparam int CONV_CYCLES       = (CONV_TIME_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int LIGHT_WAKE_CYCLES = (LIGHT_WAKE_TIME_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int DEEP_WAKE_CYCLES  = (DEEP_WAKE_TIME_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int CNT_W                     = 8;

  typedef enum logic [2:0] {
    ST_ACQ,
    ST_CONV,
    ST_LIGHT_SLEEP,
    ST_LIGHT_WAKE,
    ST_DEEP_SLEEP,
    ST_DEEP_WAKE
  } alpm_state_t;

endpackage

//--- alpm_properties.sv
// Checker for the low-power mode controller
`timescale 1ns/1ns
module alpm_chk(input wire logic CLOCK_I, SYS_RST_I, CONV_START_SELECT_I, UNLOCKED_O, ANALOG_PWR_O,
  LIGHT_SLEEP_O, DEEP_SLEEP_O, CONV_BUSY_O, HOST_READY_O, input wire logic [7:0] PWRCTL_O);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  wire c = CONV_START_SELECT_I, l = LIGHT_SLEEP_O, p = DEEP_SLEEP_O, b = CONV_BUSY_O;
  AST_LOCK: assert property ($changed(PWRCTL_O) |-> $past(UNLOCKED_O)) else $error("lock");
  AST_LS_IN: assert property ($fell(b) && c && PWRCTL_O[0] |-> ##[0:2] l) else $error("ls in");
  AST_LS_OUT: assert property ($fell(c) && l |-> ##3 !l) else $error("ls out");
  AST_DS_IN: assert property ($rose(c) && PWRCTL_O[1] && !l |-> ##3 p) else $error("ds in");
  AST_DS_PWR: assert property (p |-> !ANALOG_PWR_O) else $error("ds pwr");
  AST_DS_RDY: assert property (p |-> HOST_READY_O) else $error("ds rdy");
  AST_DS_OUT: assert property ($fell(PWRCTL_O[1]) && p |-> ##[0:2] !p && HOST_READY_O) else $error("ds out");
  AST_NO_LS: assert property ($fell(b) && !PWRCTL_O[0] |-> !l [*3]) else $error("ls");
  cover property (l);
  cover property (p);
  cover property ($fell(p));
endmodule
bind alpm_ctrl alpm_chk chk(.*);

//--- tb.sv
// Bench for the low-power mode controller
`timescale 1ns/1ns
module tb;
  logic CLOCK_I = 0, SYS_RST_I = 1, CONV_START_SELECT_I, REG_WR_I, UNLOCKED_O, ANALOG_PWR_O;
  logic LIGHT_SLEEP_O, DEEP_SLEEP_O, CONV_BUSY_O, HOST_READY_O;
  logic [7:0] REG_ADDR_I, REG_DATA_I, PWRCTL_O;
  int error_cnt, samples_checked, m;
  alpm_ctrl uut(.*);
  alpm_host h(.*);
  initial forever #50 CLOCK_I = ~CLOCK_I;
  task c(input logic [7:0] g, e);
    samples_checked++;
    if (g !== e) begin error_cnt++; $display("Error %0t: %h not %h", $time, g, e); end
  endtask
  task s(input logic [7:0] v);
    h.w(alpm_pkg::UNLOCK_ADDR, alpm_pkg::UNLOCK_KEY);
    h.w(alpm_pkg::PWRCTL_ADDR, v);
    m = v;
    @(negedge CLOCK_I) c(PWRCTL_O, m[7:0]);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin #100000 error_cnt++; give_verdict; end
  initial begin
    void'($urandom(32'hc494));
    repeat (2) @(posedge CLOCK_I);
    SYS_RST_I <= 0;
    @(negedge CLOCK_I) c(PWRCTL_O, alpm_pkg::PWRCTL_RESET);
    h.w(alpm_pkg::PWRCTL_ADDR, 8'($urandom | 3));
    @(negedge CLOCK_I) c(PWRCTL_O, alpm_pkg::PWRCTL_RESET);
    s(1);
    h.p(1, alpm_pkg::CONV_CYCLES + 4);
    c(LIGHT_SLEEP_O, 1);
    h.p(0, alpm_pkg::LIGHT_WAKE_CYCLES);
    c(LIGHT_SLEEP_O, 0);
    $display("light sleep done");
    s(0);
    h.p(1, alpm_pkg::CONV_CYCLES + 4);
    c({LIGHT_SLEEP_O, ANALOG_PWR_O}, 1);
    h.p(0, 2);
    $display("normal done");
    s(2);
    h.p(1, 4);
    c({DEEP_SLEEP_O, HOST_READY_O, ANALOG_PWR_O}, 6);
    s(0);
    @(negedge CLOCK_I) c({DEEP_SLEEP_O, HOST_READY_O}, 1);
    h.p(0, alpm_pkg::DEEP_WAKE_CYCLES);
    h.p(1, 4);
    c(CONV_BUSY_O, 1);
    $display("deep sleep done");
    give_verdict;
  end
endmodule
